// ---- common/fsq_params.svh ----
// Offsets, field positions, reset values and timing counts of the fetch sequencer
`ifndef FSQ_PARAMS_SVH
`define FSQ_PARAMS_SVH
// Register indices; byte address is four times the index
`define FSQ_IDX_PC_LOW       8'h06
`define FSQ_IDX_TBL_PTR      8'h07
`define FSQ_IDX_TBL_HIGH     8'h08
`define FSQ_IDX_BANK_SEL     8'h1C
`define FSQ_IDX_SEQ_STATUS   8'h20
// Reset values
`define FSQ_RST_PC           13'h0000
`define FSQ_RST_BANK         2'h0
`define FSQ_RST_BYTE         8'h00
// Interrupt vectors within the current bank
`define FSQ_VEC_TMR0         13'h0008
`define FSQ_VEC_TMR1         13'h000C
// Timing: oscillator halved, four phases per instruction cycle
`define FSQ_OSC_DIV          2
`define FSQ_PHASES           4
`define FSQ_PCLK_PER_ICYC    (`FSQ_OSC_DIV * `FSQ_PHASES)
`define FSQ_CNT_LAST         3'h7
`define FSQ_CNT_SAMPLE_END   3'h1
// Address layout
`define FSQ_SAMPLE_SHIFT     5
`define FSQ_PAGE_LSB         8
`define FSQ_LAST_PAGE        5'h1F
`endif

// ---- common/fsq_pkg.sv ----
// Types shared by the fetch sequencer and its decoder
`default_nettype none
package fsq_pkg;
    // Control request from the instruction decoder for the word being executed
    typedef enum logic [2:0] {
        FSQ_OP_NONE  = 3'h0,
        FSQ_OP_JUMP  = 3'h1,
        FSQ_OP_CALL  = 3'h2,
        FSQ_OP_RET   = 3'h3,
        FSQ_OP_SKIP  = 3'h4,
        FSQ_OP_TBL_C = 3'h5,
        FSQ_OP_TBL_L = 3'h6
    } fsq_op_t;
    typedef struct packed {
        fsq_op_t     op;       // Control action
        logic [12:0] target;   // Jump or call destination
        logic [7:0]  ram_addr; // Table read low-byte destination
    } fsq_cmd_t;
    // Table read low byte toward data memory
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } fsq_ram_wr_t;
endpackage
`default_nettype wire

// ---- rtl/fsq_seq.sv ----
// Fetch sequencer: phase timing, program counter, ROM addressing and table reads
//
// Overview of operation
// - System clock is oscillator divided by two
// - Instruction cycle is four non-overlapping phases
// - Fetch one cycle, execute the next
// - Program counter changes cost a dummy cycle
// - Program counter is thirteen bits wide
// - Counter increments after each fetch
// - Taken skip discards next word, continues plus two
// - Low byte write jumps within page
// - Reset starts at word zero, bank zero
// - Timer 0 vector 008H keeps bank
// - Timer 1 vector 00CH keeps bank
// - Jump and call load code field
// - Return reloads counter from stack top
// - Program address is bank above counter
// - Sample address is start shifted five
// - Table read splits word into two bytes
// - Table pointer readable, writable, loaded before read
// - Table high byte ignores writes
// - Table read takes two instruction cycles
// - Bank change applies after following instruction
// - Table page from counter or forced ones
// - Call and interrupt push the counter
`include "fsq_params.svh"
`default_nettype none
module fsq_seq #(
    parameter int PC_W   = 13,
    parameter int ROM_AW = 16
) (
    // Clock, reset, enable
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               clk_en,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Shared ROM
    output logic      [15:0]        rom_address_lines,
    input  wire logic [15:0]        rom_rdata,
    // Decoder side
    output logic      [15:0]        instr_word,
    output logic                    instr_exec,
    input  wire fsq_pkg::fsq_cmd_t  exec_cmd,
    // Return stack side
    input  wire logic [12:0]        stack_top,
    input  wire logic               stack_full,
    output logic                    stack_push,
    output logic                    stack_pop,
    output logic      [12:0]        push_addr,
    // Timer interrupts
    input  wire logic               tmr0_ovf,
    input  wire logic               tmr0_ien,
    input  wire logic               tmr1_ovf,
    input  wire logic               tmr1_ien,
    // Wavetable sample fetch
    input  wire logic               sample_req,
    input  wire logic [15:0]        sample_start_address,
    output logic      [15:0]        sample_data,
    output logic                    sample_valid,
    // Data memory write and timing
    output fsq_pkg::fsq_ram_wr_t    ram_wr,
    output logic      [3:0]         phase_clk,
    output logic                    sys_clk
);
    import fsq_pkg::*;

    // Only the documented widths are served
    if (PC_W != 13 || ROM_AW != 16) begin : g_width_chk
        $error("fsq_seq: PC_W must be 13 and ROM_AW 16");
    end

    // Slot kind of the current instruction cycle
    typedef enum logic [2:0] {
        FSQ_S_EXEC  = 3'b001,
        FSQ_S_DUMMY = 3'b010,
        FSQ_S_TABLE = 3'b100
    } fsq_slot_t;

    fsq_slot_t   slot_r;          // What this instruction cycle does
    fsq_slot_t   slot_nxt;        // Slot of the next cycle
    logic [2:0]  cnt_r;           // pclk count inside an instruction cycle
    logic [12:0] pc_r;            // Address being fetched this cycle
    logic [12:0] pc_nxt;          // Counter after this cycle
    logic [15:0] instr_r;         // Word fetched last cycle
    logic [1:0]  bank_r;          // Bank used for fetches
    logic [1:0]  bank_wr_r;       // Last bank written by software
    logic [1:0]  bank_mid_r;      // Bank waiting one instruction
    logic [1:0]  bank_dly_r;      // Pending-apply stages
    logic [7:0]  tbl_ptr_r;       // Table pointer
    logic [7:0]  tbl_high_r;      // Table high byte
    logic        tbl_last_r;      // Table read targets the last page
    logic [7:0]  tbl_dst_r;       // Low byte destination
    logic [7:0]  pcl_wdat_r;      // Short jump destination byte
    logic        pcl_pend_r;      // Short jump awaiting cycle end
    logic        irq0_pend_r;     // Latched timer 0 request
    logic        irq1_pend_r;     // Latched timer 1 request
    logic        cyc_end;         // Last pclk of an instruction cycle
    logic        exec_ok;         // Executing a real word
    logic        take_irq;        // Vectoring after a plain word
    logic        ctl_xfer;        // Counter loaded non-sequentially
    logic        acc_done;        // APB access completes
    logic        wr_done;         // APB write completes
    logic [7:0]  reg_idx;         // Word index; aliases map to unused FFH
    logic [31:0] rd_mux;          // Read data for the index
    logic        rd_hit;          // Index is mapped
    logic [15:0] prog_addr;       // Program or table ROM address
    logic [15:0] smp_addr;        // Wavetable ROM address

    assign cyc_end  = clk_en && (cnt_r == `FSQ_CNT_LAST);
    assign exec_ok  = (slot_r == FSQ_S_EXEC);
    assign take_irq = exec_ok && !stack_full && (irq0_pend_r || irq1_pend_r) &&
                      exec_cmd.op == FSQ_OP_NONE && !pcl_pend_r;
    assign acc_done = clk_en && psel && penable && pready;
    assign wr_done  = acc_done && pwrite;
    assign reg_idx  = (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0) ? paddr[9:2] : 8'hFF;

    // Cycle counter: bit 0 halves, upper bits pick the phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 3'h0;
        end else if (clk_en) begin
            cnt_r <= cnt_r + 3'h1;
        end
    end

    // Halved system clock and one-hot phase clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk   <= 1'b0;
            phase_clk <= 4'h0;
        end else if (clk_en) begin
            sys_clk   <= ~cnt_r[0];
            phase_clk <= 4'h1 << (2'(cnt_r[2:1] + {1'b0, cnt_r[0]}));
        end
    end

    // Next counter and slot; interrupts only between real words
    always_comb begin
        pc_nxt   = pc_r + 13'h1;
        slot_nxt = FSQ_S_EXEC;
        ctl_xfer = 1'b0;
        case (slot_r)
            FSQ_S_EXEC: begin
                if (take_irq) begin
                    pc_nxt   = irq0_pend_r ? `FSQ_VEC_TMR0 : `FSQ_VEC_TMR1;
                    ctl_xfer = 1'b1;
                end else begin
                    case (exec_cmd.op)
                        FSQ_OP_JUMP, FSQ_OP_CALL: begin
                            pc_nxt   = exec_cmd.target;
                            ctl_xfer = 1'b1;
                        end
                        FSQ_OP_RET: begin
                            pc_nxt   = stack_top;
                            ctl_xfer = 1'b1;
                        end
                        FSQ_OP_SKIP: begin
                            pc_nxt   = pc_r + 13'h1;
                            ctl_xfer = 1'b1;
                        end
                        FSQ_OP_TBL_C, FSQ_OP_TBL_L: begin
                            pc_nxt   = pc_r + 13'h1;
                            slot_nxt = FSQ_S_TABLE;
                        end
                        default: begin
                            if (pcl_pend_r) begin
                                pc_nxt   = {pc_r[12:8], pcl_wdat_r};
                                ctl_xfer = 1'b1;
                            end
                        end
                    endcase
                end
                if (ctl_xfer) begin
                    slot_nxt = FSQ_S_DUMMY;
                end
            end
            FSQ_S_TABLE: begin
                // Held word was fetched already; counter waits
                pc_nxt = pc_r;
            end
            FSQ_S_DUMMY: begin
                pc_nxt = pc_r + 13'h1;
            end
            default: begin
                slot_nxt = FSQ_S_DUMMY;
            end
        endcase
    end

    // Program counter and slot advance once per instruction cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r   <= `FSQ_RST_PC;
            slot_r <= FSQ_S_DUMMY;
        end else if (cyc_end) begin
            pc_r   <= pc_nxt;
            slot_r <= slot_nxt;
        end
    end

    // Fetched word register; kept across the table slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r    <= 16'h0000;
            instr_exec <= 1'b0;
        end else if (cyc_end) begin
            if (slot_r != FSQ_S_TABLE) begin
                instr_r <= rom_rdata;
            end
            instr_exec <= (slot_nxt == FSQ_S_EXEC);
        end
    end
    assign instr_word = instr_r;

    // Stack strobes: calls and interrupts push, returns pop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_push <= 1'b0;
            stack_pop  <= 1'b0;
            push_addr  <= 13'h0000;
        end else if (clk_en) begin
            stack_push <= cyc_end && exec_ok && (take_irq || exec_cmd.op == FSQ_OP_CALL);
            stack_pop  <= cyc_end && exec_ok && !take_irq && exec_cmd.op == FSQ_OP_RET;
            if (cyc_end && exec_ok) begin
                // Fetched word is discarded on interrupt, so it is the return point
                push_addr <= pc_r;
            end
        end
    end

    // Pending timer requests; a new overflow wins over the clearing vector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq0_pend_r <= 1'b0;
            irq1_pend_r <= 1'b0;
        end else if (clk_en) begin
            if (tmr0_ovf && tmr0_ien) begin
                irq0_pend_r <= 1'b1;
            end else if (cyc_end && take_irq && irq0_pend_r) begin
                irq0_pend_r <= 1'b0;
            end
            if (tmr1_ovf && tmr1_ien) begin
                irq1_pend_r <= 1'b1;
            end else if (cyc_end && take_irq && !irq0_pend_r) begin
                irq1_pend_r <= 1'b0;
            end
        end
    end

    // Bank select: written value reaches fetches two cycle ends later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_r     <= `FSQ_RST_BANK;
            bank_wr_r  <= `FSQ_RST_BANK;
            bank_mid_r <= `FSQ_RST_BANK;
            bank_dly_r <= 2'h0;
        end else if (clk_en) begin
            if (wr_done && reg_idx == `FSQ_IDX_BANK_SEL) begin
                bank_wr_r  <= pwdata[1:0];
                bank_dly_r <= 2'h2;
            end else if (cyc_end && bank_dly_r != 2'h0) begin
                bank_dly_r <= bank_dly_r - 2'h1;
            end
            if (cyc_end) begin
                bank_mid_r <= bank_wr_r;
                if (bank_dly_r == 2'h1) begin
                    bank_r <= bank_mid_r;
                end
            end
        end
    end

    // Table pointer and short jump byte from software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbl_ptr_r  <= `FSQ_RST_BYTE;
            pcl_wdat_r <= `FSQ_RST_BYTE;
            pcl_pend_r <= 1'b0;
        end else if (clk_en) begin
            if (wr_done && reg_idx == `FSQ_IDX_TBL_PTR) begin
                tbl_ptr_r <= pwdata[7:0];
            end
            if (wr_done && reg_idx == `FSQ_IDX_PC_LOW) begin
                pcl_wdat_r <= pwdata[7:0];
                pcl_pend_r <= 1'b1;
            end else if (cyc_end && ctl_xfer && exec_cmd.op == FSQ_OP_NONE && !take_irq) begin
                pcl_pend_r <= 1'b0;
            end
        end
    end

    // Table read request captured from the executing word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbl_last_r <= 1'b0;
            tbl_dst_r  <= `FSQ_RST_BYTE;
        end else if (cyc_end && exec_ok && !take_irq) begin
            tbl_last_r <= (exec_cmd.op == FSQ_OP_TBL_L);
            tbl_dst_r  <= exec_cmd.ram_addr;
        end
    end

    // Table word split: low byte to data memory, high byte held here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbl_high_r <= `FSQ_RST_BYTE;
            ram_wr     <= '0;
        end else if (clk_en) begin
            ram_wr.we <= 1'b0;
            if (cyc_end && slot_r == FSQ_S_TABLE) begin
                tbl_high_r  <= rom_rdata[15:8];
                ram_wr.we   <= 1'b1;
                ram_wr.addr <= tbl_dst_r;
                ram_wr.data <= rom_rdata[7:0];
            end
        end
    end

    // ROM address forms: program, table page and wavetable sample
    always_comb begin
        if (slot_r == FSQ_S_TABLE) begin
            prog_addr = {1'b0, bank_r,
                         tbl_last_r ? `FSQ_LAST_PAGE : pc_r[12:8], tbl_ptr_r};
        end else begin
            prog_addr = {1'b0, bank_r, pc_r};
        end
        smp_addr = {sample_start_address[10:0], 5'h00};
    end

    // Shared ROM port: first system clock sample, the rest program
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_address_lines <= 16'h0000;
        end else if (clk_en) begin
            // Sample slot is cnt 0..1; table and program keep cnt 2..7
            rom_address_lines <= ((cnt_r == `FSQ_CNT_LAST || cnt_r == 3'h0) && sample_req) ?
                                 smp_addr : prog_addr;
        end
    end

    // Sample word capture at end of its slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_data  <= 16'h0000;
            sample_valid <= 1'b0;
        end else if (clk_en) begin
            sample_valid <= 1'b0;
            if (cnt_r == `FSQ_CNT_SAMPLE_END && rom_address_lines == smp_addr && sample_req) begin
                sample_data  <= rom_rdata;
                sample_valid <= 1'b1;
            end
        end
    end

    // Register read decode; high byte writes are simply dropped
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (reg_idx)
            `FSQ_IDX_PC_LOW:     rd_mux = {24'h000000, pc_r[7:0]};
            `FSQ_IDX_TBL_PTR:    rd_mux = {24'h000000, tbl_ptr_r};
            `FSQ_IDX_TBL_HIGH:   rd_mux = {24'h000000, tbl_high_r};
            `FSQ_IDX_BANK_SEL:   rd_mux = {30'h0, bank_wr_r};
            `FSQ_IDX_SEQ_STATUS: rd_mux = {12'h000, irq1_pend_r, irq0_pend_r, slot_r,
                                           bank_r, pc_r};
            default:             rd_hit = 1'b0;
        endcase
    end

    // APB slave: no wait states, ready and data registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end
endmodule // fsq_seq
`default_nettype wire

// ---- tb/fsq_rom_model.sv ----
// Shared program and wavetable ROM model
`default_nettype none
module fsq_rom_model (
    // Address from the sequencer
    input  wire logic [15:0] rom_address_lines,
    // Word at that address, no latency
    output logic      [15:0] rom_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [64]; // Low 64 words, shared by all banks
    // Test program; untouched words hold their own offset, a no-op
    initial begin
        for (int i = 0; i < 64; i++) mem[i] = 16'(i);
        mem[6'h02] = 16'h2010; // Jump to 010H
        mem[6'h08] = 16'h6008; // Timer 0 service: return, no table read
        mem[6'h0C] = 16'h600C; // Timer 1 service: return
        mem[6'h10] = 16'h8000; // Taken skip
        mem[6'h12] = 16'h4020; // Call 020H
        mem[6'h20] = 16'hA040; // Current page table read to 40H
        mem[6'h21] = 16'hC041; // Last page table read to 41H
        mem[6'h22] = 16'h6000; // Return
        mem[6'h35] = 16'h1FEF; // Table data
    end
    // Upper area answers with its offset, so sample words are predictable
    assign rom_rdata = (rom_address_lines[15] == 1'b0 && rom_address_lines[12:6] == 7'h0) ?
        mem[rom_address_lines[5:0]] : {3'h0, rom_address_lines[12:0]};
endmodule // fsq_rom_model
`default_nettype wire

// ---- tb/fsq_seq_props.sv ----
// Port checker for the fetch sequencer
`include "fsq_params.svh"
`default_nettype none
module fsq_seq_props (
    // Clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // Register bus
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // Core side
    input wire logic                 instr_exec,
    input wire logic                 stack_push,
    input wire logic                 stack_pop,
    input wire logic                 sample_valid,
    input wire fsq_pkg::fsq_ram_wr_t ram_wr,
    input wire logic [3:0]           phase_clk,
    input wire logic                 sys_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    import fsq_pkg::*;
    logic mapped; // Access hits a decoded register
    // Decoded word addresses only; anything else must be refused
    assign mapped = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 &&
        paddr[9:2] inside {`FSQ_IDX_PC_LOW, `FSQ_IDX_TBL_PTR, `FSQ_IDX_TBL_HIGH,
                           `FSQ_IDX_BANK_SEL, `FSQ_IDX_SEQ_STATUS};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // System clock toggles every bus clock
    AST_SYSCLK_HI: assert property ($rose(sys_clk) |=> $fell(sys_clk))
        else $error("system clock high too long");
    AST_SYSCLK_LO: assert property ($fell(sys_clk) |=> $rose(sys_clk))
        else $error("system clock low too long");
    // Phases: one-hot, two bus clocks each, first phase back after eight
    AST_PHASE_HOT: assert property ($onehot0(phase_clk))
        else $error("phase clocks overlap");
    // First phase after reset may be short, so it is skipped
    AST_PHASE_SEQ: assert property ($rose(phase_clk[0]) && $past(phase_clk) != 4'h0 |=>
        phase_clk[0] ##1 !phase_clk[0] [*6] ##1 phase_clk[0])
        else $error("phase timing wrong");
    // Bus answers in the first access cycle, and only there
    AST_APB_READY: assert property (psel && penable |-> pready)
        else $error("no ready in access cycle");
    AST_APB_ONLY: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    AST_APB_UNMAPPED: assert property (psel && penable && !mapped |->
        pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    AST_APB_MAPPED: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped access refused");
    // Call, interrupt and return are followed by a dummy slot
    AST_PUSH_DUMMY: assert property (stack_push |-> ##[0:8] !instr_exec)
        else $error("no dummy slot after push");
    AST_POP_DUMMY: assert property (stack_pop |-> ##[0:8] !instr_exec)
        else $error("no dummy slot after pop");
    // Table byte write and sample strobe are single pulses
    AST_TBL_PULSE: assert property (ram_wr.we |=> !ram_wr.we)
        else $error("table write longer than one cycle");
    AST_SAMPLE_PULSE: assert property (sample_valid |=> !sample_valid)
        else $error("sample strobe longer than one cycle");
endmodule // fsq_seq_props
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the fetch sequencer
`include "fsq_params.svh"
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fsq_pkg::*;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] rom_address_lines, rom_rdata, instr_word, sample_start_address, sample_data, ea;
    logic [12:0] stack_top, push_addr, first_push;
    logic        instr_exec, stack_full, stack_push, stack_pop, sample_req, sample_valid;
    logic        tmr0_ovf, tmr0_ien, tmr1_ovf, tmr1_ien, sys_clk, err, ok;
    logic [3:0]  phase_clk;
    fsq_cmd_t    exec_cmd;
    fsq_ram_wr_t ram_wr;
    fsq_ram_wr_t rq[$];       // Table byte writes seen
    logic [16:0] lg[$];       // Exec flag and word per slot
    int          mismatches = 0, n_checks = 0, n_push = 0, cyc = 0, n0;
    // Expected slots from reset: jump, skip, call, two table reads, return
    logic [16:0] exp_s [16] = '{17'h10000, 17'h10001, 17'h12010, 17'h0, 17'h18000, 17'h0,
        17'h14020, 17'h0, 17'h1A040, 17'h0, 17'h1C041, 17'h0, 17'h16000, 17'h0,
        17'h10013, 17'h10014};
    fsq_seq fsq_seq_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rom_address_lines, .rom_rdata, .instr_word, .instr_exec,
        .exec_cmd, .stack_top, .stack_full, .stack_push, .stack_pop, .push_addr, .tmr0_ovf,
        .tmr0_ien, .tmr1_ovf, .tmr1_ien, .sample_req, .sample_start_address, .sample_data,
        .sample_valid, .ram_wr, .phase_clk, .sys_clk);
    fsq_rom_model fsq_rom_model_i (.rom_address_lines, .rom_rdata);
    // Bus clock, 8 ns
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Decoder stand-in; settled long before the slot's last clock
    always @(posedge pclk) exec_cmd <= fsq_cmd_t'({instr_word, instr_word[7:0]});
    // Pushes, table writes and hang guard
    always @(posedge pclk) begin
        cyc++;
        if (ram_wr.we === 1'b1) rq.push_back(ram_wr);
        if (stack_push === 1'b1) begin
            if (n_push == 0) first_push = push_addr;
            n_push++;
        end
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end
    // Slot log: one sample per instruction cycle after the first real word
    initial begin
        @(posedge presetn);
        @(negedge pclk iff instr_exec === 1'b1);
        repeat (16) begin
            lg.push_back({instr_exec, instr_word});
            repeat (`FSQ_PCLK_PER_ICYC) @(negedge pclk);
        end
    end
    // One register bus transfer; holds everything until ready is sampled
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) mismatches++;
    endtask
    // Wait, bounded, until the given word executes
    task automatic wait_word(input logic [15:0] w);
        ok = 1'b0;
        for (int i = 0; i < 600 && !ok; i++) begin
            @(negedge pclk);
            ok = instr_exec === 1'b1 && instr_word === w;
        end
    endtask
    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {tmr0_ovf, tmr1_ovf, sample_req, stack_full, sample_start_address} = '0;
        {tmr0_ien, tmr1_ien, clk_en} = 3'h7;
        stack_top = 13'h0013;
        exec_cmd = '0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, `FSQ_IDX_TBL_PTR, 32'h35);
        for (int i = 0; i < 400 && lg.size() < 16; i++) @(negedge pclk);
        foreach (exp_s[i])
            if (exp_s[i][16]) `CHK("word", exp_s[i], lg[i])
            else `CHK("dummy", 1'b0, lg[i][16])
        `CHK("push", 13'h0013, first_push)
        `CHK("tbl cur", 17'h140EF, rq[0])
        `CHK("tbl last", 17'h14135, rq[1])
        apb(1'b0, `FSQ_IDX_TBL_PTR, 32'h0);
        `CHK("pointer", 32'h35, rd)
        apb(1'b1, `FSQ_IDX_TBL_HIGH, 32'h55);
        apb(1'b0, `FSQ_IDX_TBL_HIGH, 32'h0);
        `CHK("high byte", 32'h1F, rd)
        apb(1'b0, `FSQ_IDX_BANK_SEL, 32'h0);
        `CHK("bank", 32'h0, rd)
        apb(1'b0, 8'h3F, 32'h0);
        `CHK("unmapped", 33'h100000000, {err, rd})
        apb(1'b1, `FSQ_IDX_PC_LOW, 32'h30);
        wait_word(16'h0030);
        `CHK("short jump", 1'b1, ok)
        apb(1'b1, `FSQ_IDX_BANK_SEL, 32'h1);
        ok = 1'b1;
        repeat (`FSQ_PCLK_PER_ICYC) begin
            @(negedge pclk);
            if (rom_address_lines[14:13] !== 2'h0) ok = 1'b0;
        end
        `CHK("bank delay", 1'b1, ok)
        for (int i = 0; i < 64 && rom_address_lines[14:13] !== 2'h1; i++) @(negedge pclk);
        `CHK("bank addr", 3'h1, rom_address_lines[15:13])
        // Both timers while the stack is full: held, then served
        n0 = n_push;
        @(posedge pclk);
        stack_full <= 1'b1;
        {tmr0_ovf, tmr1_ovf} <= 2'h3;
        @(posedge pclk);
        {tmr0_ovf, tmr1_ovf} <= 2'h0;
        repeat (64) @(posedge pclk);
        `CHK("held", n0, n_push)
        stack_full <= 1'b0;
        wait_word(16'h6008);
        `CHK("vector 0", 1'b1, ok)
        `CHK("vector bank", 2'h1, rom_address_lines[14:13])
        wait_word(16'h600C);
        `CHK("vector 1", 1'b1, ok)
        `CHK("irq pushes", n0 + 2, n_push)
        // Sample fetch; upper start bits fall off the shift
        @(posedge pclk);
        sample_start_address <= 16'hF923;
        sample_req <= 1'b1;
        ea = 16'hF923 << `FSQ_SAMPLE_SHIFT;
        for (int i = 0; i < 32 && sample_valid !== 1'b1; i++) @(negedge pclk);
        `CHK("sample", {3'h0, ea[12:0]}, sample_data)
        results();
    end
endmodule // testbench
bind fsq_seq fsq_seq_props fsq_seq_props_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .instr_exec, .stack_push, .stack_pop, .sample_valid,
    .ram_wr, .phase_clk, .sys_clk);
`default_nettype wire
